// ==== design/ddsc_map.vh ====
`ifndef DDSC_MAP_VH
`define DDSC_MAP_VH

// Command word layout, bit 15 shifted in first
`define DDSC_WORD_BITS      16
`define DDSC_DATA_BITS      8
`define DDSC_POS_SPARE1     15
`define DDSC_POS_SPARE2     14
`define DDSC_POS_SPARE3     13
`define DDSC_POS_SHDN_B     12
`define DDSC_POS_SHDN_A     11
`define DDSC_POS_SPARE4     10
`define DDSC_POS_LOAD_B     9
`define DDSC_POS_LOAD_A     8
`define DDSC_DATA_MSB       7
`define DDSC_DATA_LSB       0

// Reset values
`define DDSC_RST_CODE       8'h00
`define DDSC_RST_SHDN       1'b0
`define DDSC_RST_WORD       16'h0000
`define DDSC_RST_COUNT      5'h00

// Idle levels of the link pins, used as synchroniser reset values
`define DDSC_IDLE_SCLK      1'b0
`define DDSC_IDLE_SELECT    1'b1
`define DDSC_IDLE_DATA      1'b0

// Converter full scale divisor
`define DDSC_FULL_SCALE     256

`endif

// ==== design/ddsc_sync.v ====
`timescale 1ns/1ps
// Two-flop synchroniser for one level from another domain
module ddsc_sync #(
   parameter [0:0] RST_VAL = 1'b0
) (
   input  wire clk,
   input  wire rst,
   input  wire d,
   output reg  q
);
   reg meta;

   // First stage is read only by the second stage
   // Reset level matches the pin's idle level, so no false edge follows
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// ==== design/ddsc_serial_dac.v ====
`timescale 1ns/1ps
`include "ddsc_map.vh"

// Functional notes
// [R1] A command is 16 bits: control byte followed by data byte.
// [R2] Control bits are not decoded; each bit acts on its own.
// [R3] Order: spares 1-3, shut B, shut A, spare 4, load B, load A, data.
// [R4] Load-A high copies data byte into channel A register.
// [R5] Load-B high copies data byte into channel B register.
// [R6] Both loads high write the same byte to both registers.
// [R7] Both loads low leave registers unchanged, data ignored.
// [R8] Shutdown bits active high per channel; both zero runs all.
// [R9] Load and shutdown bits of one word act together.
// [R10] Output equals reference times code over 256.
// [R11] Reset clears registers to zero and outputs to zero scale.
// [R12] Host writes an initial command after power-up.
// [R13] Host uses clock polarity and phase zero; clock idles low.
// [R14] Host changes data on falling clock edges.
// [R15] Host toggles clock only during transfers.
// [R16] Host sends spare three as one, spare four as zero.
// [R17] While select low, data is shifted in on rising clock edges.
// [R18] Select rising after 16 bits executes the command.
// [R19] Shutdown forces output to zero but keeps register value.
// [R20] Host may split a write into two bytes with select held low.
module ddsc_serial_dac #(
   parameter WORD_BITS = `DDSC_WORD_BITS,
   parameter DATA_BITS = `DDSC_DATA_BITS
) (
   input  wire                 clk,
   input  wire                 rst,
   input  wire                 serial_clock,
   input  wire                 serial_data,
   input  wire                 chip_select_n,
   output reg  [DATA_BITS-1:0] channel_a_code,
   output reg  [DATA_BITS-1:0] channel_b_code,
   output reg                  shutdown_channel_a,
   output reg                  shutdown_channel_b,
   output reg  [DATA_BITS-1:0] channel_a_output,
   output reg  [DATA_BITS-1:0] channel_b_output,
   output reg                  command_done
);
   // Frame tracker states
   localparam [1:0] FRM_IDLE  = 2'b00;
   localparam [1:0] FRM_SHIFT = 2'b01;
   localparam [1:0] FRM_FULL  = 2'b10;

   wire                 sclk_s;
   wire                 din_s;
   wire                 csn_s;
   reg                  sclk_d;
   reg                  csn_d;
   reg  [WORD_BITS-1:0] shift_word;
   reg  [4:0]           bit_count;
   reg  [1:0]           frame_state;
   reg  [1:0]           next_frame_state;
   wire                 sclk_rise;
   wire                 cs_rise;
   wire                 last_bit;
   wire                 word_full;
   wire                 execute;
   wire                 load_channel_a;
   wire                 load_channel_b;
   wire                 next_shut_a;
   wire                 next_shut_b;
   wire [DATA_BITS-1:0] data_byte;
   reg  [DATA_BITS-1:0] next_code_a;
   reg  [DATA_BITS-1:0] next_code_b;
   reg  [DATA_BITS-1:0] next_out_a;
   reg  [DATA_BITS-1:0] next_out_b;

   // Sizes a bit count to the width of the counter
   function [4:0] count_of;
      input integer n;
      begin
         count_of = n[4:0];
      end
   endfunction

   // Counter end points: last bit being taken, and word complete
   localparam [4:0] COUNT_FULL = count_of(WORD_BITS);
   localparam [4:0] COUNT_LAST = count_of(WORD_BITS - 1);

   // Output scaling: code/256 of reference, shutdown gives zero scale
   function [DATA_BITS-1:0] scaled_out;
      input [DATA_BITS-1:0] code;
      input                 shut;
      begin
         scaled_out = shut ? {DATA_BITS{1'b0}} : code; // [R10] [R19]
      end
   endfunction

   // Bring the three link pins into the clk domain
   ddsc_sync #(.RST_VAL(`DDSC_IDLE_SCLK)) u_sync_sclk (
      .clk (clk),
      .rst (rst),
      .d   (serial_clock),
      .q   (sclk_s)
   );
   ddsc_sync #(.RST_VAL(`DDSC_IDLE_DATA)) u_sync_din (
      .clk (clk),
      .rst (rst),
      .d   (serial_data),
      .q   (din_s)
   );
   // Select idles high: a low reset level would fake a select edge
   ddsc_sync #(.RST_VAL(`DDSC_IDLE_SELECT)) u_sync_csn (
      .clk (clk),
      .rst (rst),
      .d   (chip_select_n),
      .q   (csn_s)
   );

   // Edge detection on synchronised levels
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_d <= 1'b0;
         csn_d  <= 1'b1;
      end else begin
         sclk_d <= sclk_s;
         csn_d  <= csn_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_d;
   assign cs_rise   = csn_s & ~csn_d;
   assign last_bit  = sclk_rise & (bit_count == COUNT_LAST);
   assign word_full = (frame_state == FRM_FULL); // [R18]
   assign execute   = cs_rise & word_full; // [R18]

   // Field extraction: each control bit drives its own function
   assign load_channel_a = shift_word[`DDSC_POS_LOAD_A]; // [R2] [R3]
   assign load_channel_b = shift_word[`DDSC_POS_LOAD_B];
   assign next_shut_a    = shift_word[`DDSC_POS_SHDN_A];
   assign next_shut_b    = shift_word[`DDSC_POS_SHDN_B];
   assign data_byte = shift_word[`DDSC_DATA_MSB:`DDSC_DATA_LSB]; // [R1]

   // Next register codes from independent load bits
   always @* begin
      next_code_a = channel_a_code;
      next_code_b = channel_b_code;
      if (load_channel_a) begin
         next_code_a = data_byte; // [R4] [R6]
      end
      if (load_channel_b) begin
         next_code_b = data_byte; // [R5] [R6]
      end
      // Neither load set: codes hold, data unused [R7]
   end

   // Next output levels: effective code, zero while shut down
   always @* begin
      next_out_a = channel_a_output;
      next_out_b = channel_b_output;
      if (execute) begin
         next_out_a = scaled_out(next_code_a, next_shut_a); // [R10]
         next_out_b = scaled_out(next_code_b, next_shut_b); // [R19]
      end
   end

   // Frame tracker: a word executes only once all its bits are in
   always @* begin
      next_frame_state = frame_state;
      case (frame_state)
         FRM_IDLE: begin
            if (!csn_s) begin
               next_frame_state = FRM_SHIFT;
            end
         end
         FRM_SHIFT: begin
            if (csn_s) begin
               next_frame_state = FRM_IDLE; // Short word dropped
            end else if (last_bit) begin
               next_frame_state = FRM_FULL; // [R18]
            end
         end
         FRM_FULL: begin
            if (csn_s) begin
               next_frame_state = FRM_IDLE;
            end
         end
         default: begin
            next_frame_state = FRM_IDLE;
         end
      endcase
   end

   // Frame state register
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         frame_state <= FRM_IDLE;
      end else begin
         frame_state <= next_frame_state;
      end
   end

   // Shift register and bit counter while select is low
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         shift_word <= `DDSC_RST_WORD;
         bit_count  <= `DDSC_RST_COUNT;
      end else if (csn_s) begin
         bit_count <= `DDSC_RST_COUNT;
      end else if (sclk_rise) begin
         shift_word <= {shift_word[WORD_BITS-2:0], din_s}; // [R17]
         if (bit_count != COUNT_FULL) begin // Extra bits keep last 16
            bit_count <= bit_count + 5'h01;
         end
      end
   end

   // Execute on select rising; short words are discarded
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         channel_a_code     <= `DDSC_RST_CODE; // [R11]
         channel_b_code     <= `DDSC_RST_CODE;
         shutdown_channel_a <= `DDSC_RST_SHDN;
         shutdown_channel_b <= `DDSC_RST_SHDN;
         channel_a_output   <= `DDSC_RST_CODE;
         channel_b_output   <= `DDSC_RST_CODE;
         command_done       <= 1'b0;
      end else begin
         command_done     <= 1'b0;
         channel_a_output <= next_out_a;
         channel_b_output <= next_out_b;
         if (execute) begin
            channel_a_code     <= next_code_a; // [R9] [R18]
            channel_b_code     <= next_code_b;
            shutdown_channel_a <= next_shut_a; // [R8]
            shutdown_channel_b <= next_shut_b; // [R8]
            command_done       <= 1'b1;
         end
      end
   end
endmodule

// ==== sim/ddsc_properties.sv ====
`timescale 1ns/1ps
// Port checks of the serial command front end
module ddsc_properties (
   input wire       clk,
   input wire       rst,
   input wire       serial_clock,
   input wire       serial_data,
   input wire       chip_select_n,
   input wire       shutdown_channel_a,
   input wire       shutdown_channel_b,
   input wire       command_done,
   input wire [7:0] channel_a_code,
   input wire [7:0] channel_b_code,
   input wire [7:0] channel_a_output,
   input wire [7:0] channel_b_output
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   a_out_a_map: assert property (channel_a_output ==
      (shutdown_channel_a ? 8'h00 : channel_a_code)) else $error("out A");
   a_out_b_map: assert property (channel_b_output ==
      (shutdown_channel_b ? 8'h00 : channel_b_code)) else $error("out B");
   a_code_a_hold: assert property (!$stable(channel_a_code) |->
      command_done) else $error("code A moved");
   a_code_b_hold: assert property (!$stable(channel_b_code) |->
      command_done) else $error("code B moved");
   a_shdn_hold: assert property (!$stable({shutdown_channel_a,
      shutdown_channel_b}) |-> command_done) else $error("shutdown moved");
   a_done_pulse: assert property (command_done |=> !command_done)
      else $error("done too long");
   a_done_cs_high: assert property (command_done |-> chip_select_n &&
      $past(chip_select_n, 2)) else $error("done before select rise");
   a_reset_clear: assert property ($fell(rst) |-> !command_done &&
      channel_a_code == 8'h00 && channel_b_code == 8'h00) else $error("rst");
endmodule

// ==== sim/ddsc_host.sv ====
`timescale 1ns/1ps
// Host end of the link: clock idles low, data moves while clock is low
module ddsc_host (
   output reg serial_clock  = 1'b0,
   output reg serial_data   = 1'b0,
   output reg chip_select_n = 1'b1
);
   integer i;
   // Shifts the first n bits of a word, bit 15 first
   task send(input [15:0] w, input split, input integer n);
      w[13] = 1'b1;
      w[10] = 1'b0;
      chip_select_n = 1'b0;
      #52;
      for (i = 15; i > 15 - n; i = i - 1) begin
         serial_data = w[i];
         #16 serial_clock = 1'b1;
         #16 serial_clock = 1'b0;
         if (split && i == 8) #100;
      end
      #52 chip_select_n = 1'b1;
      serial_data = ~serial_data; // Released line shows no stale value
      #60;
   endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   reg        clk = 1'b0;
   reg        rst = 1'b1;
   wire       serial_clock, serial_data, chip_select_n, command_done;
   wire       shutdown_channel_a, shutdown_channel_b;
   wire [7:0] channel_a_code, channel_b_code;
   wire [7:0] channel_a_output, channel_b_output;
   wire [1:0] shut = {shutdown_channel_b, shutdown_channel_a};
   wire [15:0] outs = {channel_a_output, channel_b_output};
   reg  [7:0] ea = 8'h00, eb = 8'h00, oa, ob;
   reg  [1:0] es = 2'b00;
   integer    n_mismatch = 0, n_tests = 0, n_done = 0, ed = 0;
   ddsc_host ddsc_host_inst (
      .serial_clock  (serial_clock),
      .serial_data   (serial_data),
      .chip_select_n (chip_select_n)
   );
   ddsc_serial_dac ddsc_serial_dac_inst (
      .clk                (clk),
      .rst                (rst),
      .serial_clock       (serial_clock),
      .serial_data        (serial_data),
      .chip_select_n      (chip_select_n),
      .channel_a_code     (channel_a_code),
      .channel_b_code     (channel_b_code),
      .shutdown_channel_a (shutdown_channel_a),
      .shutdown_channel_b (shutdown_channel_b),
      .channel_a_output   (channel_a_output),
      .channel_b_output   (channel_b_output),
      .command_done       (command_done)
   );
   initial forever #2 clk = ~clk;
   // Counts executed commands
   always @(posedge clk) if (command_done === 1'b1) n_done <= n_done + 1;
   task check(input string name, input [15:0] seen, input [15:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Sends one word, then compares codes, shutdown state and done count
   task cmd(input [15:0] w, input split, input integer n);
      ddsc_host_inst.send(w, split, n);
      if (n == 16 && w[8]) ea = w[7:0];
      if (n == 16 && w[9]) eb = w[7:0];
      if (n == 16) es = w[12:11];
      oa = es[0] ? 8'h00 : ea; // Shut channel reads zero
      ob = es[1] ? 8'h00 : eb;
      ed = ed + (n == 16);
      check("codes", {channel_a_code, channel_b_code}, {ea, eb});
      check("state", {shut, n_done[5:0]}, {es, ed[5:0]});
      check("outputs", outs, {oa, ob});
   endtask
   task end_sim(input hang);
      n_mismatch = n_mismatch + hang;
      if (n_mismatch == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      cmd(16'h23AA, 1'b0, 8);
      cmd(16'h2355, 1'b1, 16);
      cmd(16'h21A7, 1'b0, 16);
      cmd(16'h22FF, 1'b0, 16);
      cmd(16'h3812, 1'b0, 16);
      cmd(16'h2901, 1'b0, 16);
      cmd(16'hC13C, 1'b0, 16);
      end_sim(1'b0);
   end
   initial #100000 end_sim(1'b1);
endmodule
bind ddsc_serial_dac ddsc_properties ddsc_properties_inst (.*);
